// ### wcca_defs.svh
// Constants of the write CRC check and alert block
// Operation
// - x8 burst-chop-four: column bit two low picks lower nibbles and mask bits 64-67, else upper
// - x4 and x16 trees use the same nibble choice by column bit two
// - Each x8 tree takes 32 data bits as inputs, 36 with the mask function on
// - Column bit two high feeds bits 7..4 into tree positions 3..0, every lane
// - Compare computed and received CRC; start error handling the clock after a mismatch
// - CRC errors share the active-low alert output with CA parity errors
// - CRC alert is a short pulse, ten clocks at most; parity holds over 45; here errors during a CRC pulse restart it and can pass ten
// - Alert asserts a fixed latency after the erroneous write data
// - A CRC error sets the status bit, bit 3 of mode register five
// - Setting the status bit also sets the error-log flag, bit 7 of page one
// - Status and log stay set until a mode register set writes bit 3 to 0
// - Pulse width runs from driver pulling low until driver release
`ifndef WCCA_DEFS_SVH
`define WCCA_DEFS_SVH

`define WCCA_CLK_PERIOD_NS    50
`define WCCA_ALERT_LAT_NS     13
`define WCCA_ALERT_PW_MIN_CK  6
`define WCCA_ALERT_PW_MAX_CK  10
`define WCCA_ALERT_PW_CK      8
`define WCCA_PARITY_PW_MIN_CK 46
`define WCCA_PARITY_PW_CK     48
`define WCCA_MODE_FIVE_ADDR   3'h5
`define WCCA_STATUS_POS       3
`define WCCA_LOG_FLAG_POS     7
`define WCCA_TREE_BITS        72
`define WCCA_LANE_BITS        8
`define WCCA_CRC_POLY         8'h07
`define WCCA_STATUS_RST       1'b0

`endif

// ### wcca_pkg.sv
// Types shared by the write CRC check and alert block
package wcca_pkg;

  typedef struct packed {
    logic         col_bit_two; // Column address bit two of the write
    logic [143:0] data;        // Logical data bits D[143:0]
    logic [15:0]  crc;         // Received CRC bits, tree 1 in the upper byte
  } wcca_wr_t;

  typedef struct packed {
    logic [2:0]  mr_sel;       // Mode register addressed
    logic [13:0] opcode;       // Mode register contents
  } wcca_mrs_t;

  typedef enum logic [1:0] {
    WCCA_IDLE  = 2'b00,
    WCCA_DELAY = 2'b01,
    WCCA_LOW   = 2'b10
  } wcca_pulse_state_t;

  // Bit-serial form of the x^8+x^2+x+1 tree, highest index first
  function automatic logic [7:0] wcca_crc8(input logic [71:0] d);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

endpackage

// ### wcca_alert_pulse.sv
// Delayed alert pulse generator for CRC errors, PW_CK wide, restarted by an error during the pulse
`timescale 1ns/1ps
`include "wcca_defs.svh"
module wcca_alert_pulse
  import wcca_pkg::*;
#(
  parameter int LAT_CK = 1,
  parameter int PW_CK  = `WCCA_ALERT_PW_CK
) (
  input  wire logic mclk_i,  // Command clock
  input  wire logic rst_n_i, // Synchronous reset, active low
  input  wire logic trig_i,  // One-cycle error start
  output logic      low_o    // High while the alert is to be pulled low
);

  generate
    if (LAT_CK < 1 || LAT_CK > 255 || PW_CK < `WCCA_ALERT_PW_MIN_CK || PW_CK > `WCCA_ALERT_PW_MAX_CK) begin : g_chk
      $error("wcca_alert_pulse: latency or pulse width out of range");
    end
  endgenerate

  localparam logic [7:0] LAT_LOAD = 8'(LAT_CK - 1);
  localparam logic [7:0] PW_LOAD  = 8'(PW_CK - 1);

  wcca_pulse_state_t state_reg;
  logic [7:0]        cnt_reg;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= WCCA_IDLE;
      cnt_reg   <= 8'h00;
      low_o     <= 1'b0;
    end else begin
      unique case (state_reg)
        WCCA_IDLE: begin
          if (trig_i) begin
            state_reg <= (LAT_LOAD == 8'h00) ? WCCA_LOW : WCCA_DELAY;
            cnt_reg   <= (LAT_LOAD == 8'h00) ? PW_LOAD : LAT_LOAD;
            low_o     <= (LAT_LOAD == 8'h00);
          end
        end
        WCCA_DELAY: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= WCCA_LOW;
            cnt_reg   <= PW_LOAD;
            low_o     <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        WCCA_LOW: begin
          if (trig_i) begin
            cnt_reg <= PW_LOAD; // Back-to-back errors stretch the pulse
          end else if (cnt_reg == 8'h00) begin
            state_reg <= WCCA_IDLE;
            low_o     <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= WCCA_IDLE;
          cnt_reg   <= 8'h00;
          low_o     <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### wcca_top.sv
// Write CRC check, error status and shared alert driver
`timescale 1ns/1ps
`include "wcca_defs.svh"
module wcca_top
  import wcca_pkg::*;
#(
  parameter int DQ_W      = 8,
  parameter int ALERT_PW  = `WCCA_ALERT_PW_CK,
  parameter int PARITY_PW = `WCCA_PARITY_PW_CK
) (
  input  wire logic      mclk_i,        // Command clock, 20 MHz
  input  wire logic      rst_n_i,       // Synchronous reset, active low
  input  wire logic      wr_valid_i,    // One-cycle strobe: burst-chop-four write complete
  input  wire wcca_wr_t  wr_i,          // Write data, CRC and column bit two
  input  wire logic      crc_wr_en_i,   // Write CRC enabled
  input  wire logic      mask_fn_en_i,  // Write mask or bus inversion function enabled
  input  wire logic      mrs_valid_i,   // One-cycle mode register set command
  input  wire wcca_mrs_t mrs_i,         // Mode register set address and opcode
  input  wire logic      parity_err_i,  // One-cycle CA parity error event
  output logic           alert_out_o,   // Alert pin output value, always low
  output logic           alert_oe_o,    // Alert pin driver enable, high pulls low
  output logic           crc_status_o,  // Error status bit of mode register five
  output logic           crc_log_o,     // Error-log flag of purpose page register three
  output logic           crc_err_o,     // One-cycle pulse per detected CRC error
  output logic           wr_commit_o,   // One-cycle pulse: checked write may go to the core
  output logic           wr_discard_o   // One-cycle pulse: checked write is dropped
);

  localparam int NTREE  = (DQ_W == 16) ? 2 : 1;
  localparam int NLANE  = (DQ_W == 4) ? 4 : 8;
  localparam int LAT_CK = (`WCCA_ALERT_LAT_NS / `WCCA_CLK_PERIOD_NS) < 1 ? 1
                          : (`WCCA_ALERT_LAT_NS / `WCCA_CLK_PERIOD_NS);
  localparam logic [7:0] PAR_LOAD = 8'(PARITY_PW);

  generate
    if (!(DQ_W == 4 || DQ_W == 8 || DQ_W == 16)) begin : g_chk_w
      $error("wcca_top: DQ_W must be 4, 8 or 16");
    end
    if (PARITY_PW < `WCCA_PARITY_PW_MIN_CK || PARITY_PW > 255) begin : g_chk_p
      $error("wcca_top: parity pulse width out of range");
    end
  endgenerate

  // Builds the 72 tree inputs of one tree: the nibble of each lane chosen by
  // column bit two lands in positions 3..0, the rest is filled with ones
  function automatic logic [71:0] tree_inputs(input logic [71:0] d,
                                              input logic        cb2,
                                              input logic        mask_en,
                                              input int          lanes);
    logic [71:0] t;
    t = {72{1'b1}};
    for (int l = 0; l < 9; l++) begin
      for (int k = 0; k < 4; k++) begin
        if (l < lanes) begin
          t[l*8 + k] = cb2 ? d[l*8 + 4 + k] : d[l*8 + k];
        end else if (l == 8 && lanes == 8 && mask_en) begin
          t[64 + k] = cb2 ? d[68 + k] : d[64 + k];
        end
      end
    end
    return t;
  endfunction

  // Stage 1: tree result and received CRC
  logic             s1_valid_reg;
  logic             s1_mask_reg;
  logic [15:0]      s1_calc_reg;
  logic [15:0]      s1_rx_reg;
  logic [15:0]      calc_next;

  always_comb begin
    calc_next = 16'h0000;
    for (int t = 0; t < NTREE; t++) begin
      calc_next[t*8 +: 8] = wcca_crc8(tree_inputs(wr_i.data[t*72 +: 72], wr_i.col_bit_two,
                                                  mask_fn_en_i, NLANE));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_valid_reg <= 1'b0;
      s1_mask_reg  <= 1'b0;
      s1_calc_reg  <= 16'h0000;
      s1_rx_reg    <= 16'h0000;
    end else begin
      s1_valid_reg <= wr_valid_i && crc_wr_en_i;
      s1_mask_reg  <= mask_fn_en_i;
      if (wr_valid_i && crc_wr_en_i) begin
        s1_calc_reg <= calc_next;
        s1_rx_reg   <= (NTREE == 2) ? wr_i.crc : {8'h00, wr_i.crc[7:0]};
      end
    end
  end

  // Stage 2: mismatch detected on this edge
  logic mismatch_reg;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mismatch_reg <= 1'b0;
    end else begin
      mismatch_reg <= s1_valid_reg && (s1_calc_reg != s1_rx_reg);
    end
  end

  // Only checked writes commit or drop; a mismatch drops the write only with the mask function on
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_commit_o  <= 1'b0;
      wr_discard_o <= 1'b0;
    end else begin
      wr_commit_o  <= s1_valid_reg && ((s1_calc_reg == s1_rx_reg) || !s1_mask_reg);
      wr_discard_o <= s1_valid_reg && (s1_calc_reg != s1_rx_reg) && s1_mask_reg;
    end
  end

  // Error process starts the clock after the mismatch
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      crc_err_o <= 1'b0;
    end else begin
      crc_err_o <= mismatch_reg;
    end
  end

  // Status bit and log flag: hardware set wins over a clearing command
  logic status_clr;
  assign status_clr = mrs_valid_i && (mrs_i.mr_sel == `WCCA_MODE_FIVE_ADDR)
                      && !mrs_i.opcode[`WCCA_STATUS_POS];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      crc_status_o <= `WCCA_STATUS_RST;
    end else if (mismatch_reg) begin
      crc_status_o <= 1'b1;
    end else if (status_clr) begin
      crc_status_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      crc_log_o <= `WCCA_STATUS_RST;
    end else if (mismatch_reg) begin
      crc_log_o <= 1'b1;
    end else if (status_clr) begin
      crc_log_o <= 1'b0;
    end
  end

  // CRC alert pulse after the fixed latency
  logic crc_low;

  wcca_alert_pulse #(
    .LAT_CK (LAT_CK),
    .PW_CK  (ALERT_PW)
  ) u_pulse (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .trig_i  (mismatch_reg),
    .low_o   (crc_low)
  );

  // CA parity hold, long enough to be told apart from a CRC pulse
  logic [7:0] par_cnt_reg;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      par_cnt_reg <= 8'h00;
    end else if (parity_err_i) begin
      par_cnt_reg <= PAR_LOAD;
    end else if (par_cnt_reg != 8'h00) begin
      par_cnt_reg <= par_cnt_reg - 8'h01;
    end
  end

  // Open-drain alert: value low, enable while either source pulls down
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      alert_out_o <= 1'b0;
      alert_oe_o  <= 1'b0;
    end else begin
      alert_out_o <= 1'b0;
      alert_oe_o  <= crc_low || (par_cnt_reg != 8'h00);
    end
  end

endmodule

// ### wcca_top_assertions.sv
// Checker of the write CRC check and alert block
`timescale 1ns/1ps
module wcca_top_assertions
  import wcca_pkg::*;
(
  input wire logic      mclk_i,       // Clock
  input wire logic      rst_n_i,      // Reset
  input wire logic      wr_valid_i,   // Write
  input wire logic      crc_wr_en_i,  // CRC on
  input wire logic      mrs_valid_i,  // Set command
  input wire wcca_mrs_t mrs_i,        // Set fields
  input wire logic      parity_err_i, // Parity event
  input wire logic      alert_oe_o,   // Alert drive
  input wire logic      crc_status_o, // Status
  input wire logic      crc_log_o,    // Log flag
  input wire logic      crc_err_o     // Error pulse
);
  logic       clr;
  logic       en_wr;
  logic [7:0] low_cnt_reg;
  logic       par_seen_reg;
  assign clr   = mrs_valid_i && mrs_i.mr_sel == 3'h5 && !mrs_i.opcode[3];
  assign en_wr = wr_valid_i && crc_wr_en_i;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      low_cnt_reg <= 8'h00;
    end else begin
      low_cnt_reg <= alert_oe_o ? low_cnt_reg + 8'h01 : 8'h00;
    end
  end
  // Parity pulses are long on purpose, so they are exempt from the short bound
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      par_seen_reg <= 1'b0;
    end else begin
      par_seen_reg <= parity_err_i || (par_seen_reg && (alert_oe_o || low_cnt_reg == 8'h00));
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_status_set: assert property (crc_err_o |-> crc_status_o && crc_log_o) else $error("status not set");
  a_log_mirror: assert property (crc_log_o == crc_status_o) else $error("log differs");
  a_status_hold: assert property (crc_status_o && !clr |=> crc_status_o) else $error("status lost");
  a_status_clear: assert property (clr |=> !crc_status_o || crc_err_o) else $error("not cleared");
  a_err_cause: assert property (crc_err_o |-> $past(en_wr, 3)) else $error("error without write");
  a_alert_delay: assert property (crc_err_o |-> ##1 alert_oe_o) else $error("alert late");
  a_pulse_short: assert property (!par_seen_reg |-> low_cnt_reg <= 8'h0A) else $error("pulse long");
  a_parity_alert: assert property (parity_err_i |-> ##2 alert_oe_o [*8]) else $error("no parity alert");
endmodule
bind wcca_top wcca_top_assertions wcca_top_assertions_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_valid_i(wr_valid_i), .crc_wr_en_i(crc_wr_en_i),
  .mrs_valid_i(mrs_valid_i), .mrs_i(mrs_i), .parity_err_i(parity_err_i), .alert_oe_o(alert_oe_o),
  .crc_status_o(crc_status_o), .crc_log_o(crc_log_o), .crc_err_o(crc_err_o));

// ### wcca_ctrl_model.sv
// Controller model that watches the alert line level and sorts its low pulses
`timescale 1ns/1ps
module wcca_ctrl_model (
  input  wire logic  mclk_i,    // Clock
  input  wire logic  rst_n_i,   // Reset
  input  wire logic  alert_n_i, // Alert line level
  output logic [7:0] width_o,   // Last low width
  output logic [7:0] crc_cnt_o, // Short pulses, each a retry
  output logic [7:0] par_cnt_o  // Long pulses
);
  logic [7:0] run_reg;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      run_reg   <= 8'h00;
      width_o   <= 8'h00;
      crc_cnt_o <= 8'h00;
      par_cnt_o <= 8'h00;
    end else if (!alert_n_i) begin
      run_reg <= run_reg + 8'h01;
    end else if (run_reg != 8'h00) begin
      width_o <= run_reg;
      run_reg <= 8'h00;
      if (run_reg <= 8'h2D) begin
        crc_cnt_o <= crc_cnt_o + 8'h01;
      end else begin
        par_cnt_o <= par_cnt_o + 8'h01;
      end
    end
  end
endmodule

// ### tb.sv
// Self-checking testbench of the write CRC check and alert block
`timescale 1ns/1ps
module tb;
  import wcca_pkg::*;
  localparam logic [143:0] PAT = 144'h5A_3C96_E1F0_87D2_4BA5;
  logic       mclk_i, rst_n_i, wr_valid_i, crc_wr_en_i, mask_fn_en_i, mrs_valid_i, parity_err_i;
  wcca_wr_t   wr_i;
  wcca_mrs_t  mrs_i;
  logic       alert_out_o, alert_oe_o, crc_status_o, crc_log_o, crc_err_o, wr_commit_o, wr_discard_o;
  logic       alert_n;
  logic [7:0] width, crc_cnt, par_cnt;
  int         miscompares, n_checks;
  assign alert_n = alert_oe_o ? alert_out_o : 1'b1;
  wcca_top wcca_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_valid_i(wr_valid_i), .wr_i(wr_i),
    .crc_wr_en_i(crc_wr_en_i), .mask_fn_en_i(mask_fn_en_i), .mrs_valid_i(mrs_valid_i), .mrs_i(mrs_i),
    .parity_err_i(parity_err_i), .alert_out_o(alert_out_o), .alert_oe_o(alert_oe_o),
    .crc_status_o(crc_status_o), .crc_log_o(crc_log_o), .crc_err_o(crc_err_o),
    .wr_commit_o(wr_commit_o), .wr_discard_o(wr_discard_o));
  wcca_ctrl_model wcca_ctrl_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .alert_n_i(alert_n),
    .width_o(width), .crc_cnt_o(crc_cnt), .par_cnt_o(par_cnt));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask
  function automatic logic [7:0] ref_crc(input logic cb2, input logic m);
    logic [71:0] t;
    logic [7:0]  c;
    for (int l = 0; l < 9; l++) t[l*8+:8] = {4'hF, cb2 ? PAT[l*8+4+:4] : PAT[l*8+:4]};
    if (!m) t[67:64] = 4'hF;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // One write, then commit, discard and error pulse judged at their cycles
  task automatic send(input logic cb2, input logic m, input logic en, input logic bad);
    @(posedge mclk_i);
    wr_valid_i   <= 1'b1;
    crc_wr_en_i  <= en;
    mask_fn_en_i <= m;
    wr_i         <= {cb2, PAT, 8'h00, ref_crc(cb2, m) ^ {7'h00, bad}};
    @(posedge mclk_i);
    wr_valid_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk1("commit", en & ~(bad & m), wr_commit_o);
    chk1("discard", en & bad & m, wr_discard_o);
    @(posedge mclk_i);
    #1;
    chk1("crc_err", en & bad, crc_err_o);
  endtask
  task automatic alert_chk();
    chk1("oe_early", 1'b0, alert_oe_o);
    repeat (8) begin
      @(posedge mclk_i);
      #1;
      chk1("oe", 1'b1, alert_oe_o);
      chk1("alert_val", 1'b0, alert_out_o);
    end
    @(posedge mclk_i);
    #1;
    chk1("oe_end", 1'b0, alert_oe_o);
    @(posedge mclk_i);
    #1;
  endtask
  task automatic wait_pulse();
    for (int i = 0; i < 9 && alert_oe_o !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (alert_oe_o !== 1'b1) begin
      miscompares++;
      print_verdict();
    end else begin
      for (int i = 0; i < 60 && alert_oe_o !== 1'b0; i++) begin
        @(posedge mclk_i);
        #1;
      end
      if (alert_oe_o !== 1'b0) begin
        miscompares++;
        print_verdict();
      end else begin
        @(posedge mclk_i);
        #1;
      end
    end
  endtask
  task automatic mode_register_set_cmd(input logic [2:0] sel, input logic b3);
    @(posedge mclk_i);
    mrs_valid_i <= 1'b1;
    mrs_i       <= {sel, 10'h000, b3, 3'h0};
    @(posedge mclk_i);
    mrs_valid_i <= 1'b0;
    #1;
  endtask
  task automatic t_good_maps();
    for (int i = 0; i < 4; i++) send(i[0], i[1], 1'b1, 1'b0);
    chk1("status_ok", 1'b0, crc_status_o);
  endtask
  task automatic t_bad_discard();
    send(1'b1, 1'b1, 1'b1, 1'b1);
    chk1("status", 1'b1, crc_status_o);
    chk1("log", 1'b1, crc_log_o);
    alert_chk();
    chk8("width", 8'h08, width);
    chk8("crc_pulses", 8'h01, crc_cnt);
  endtask
  task automatic t_clear();
    mode_register_set_cmd(3'h4, 1'b0);
    chk1("other_mr", 1'b1, crc_status_o);
    mode_register_set_cmd(3'h5, 1'b1);
    chk1("bit_one", 1'b1, crc_status_o);
    mode_register_set_cmd(3'h5, 1'b0);
    chk1("cleared", 1'b0, crc_status_o);
    chk1("log_cleared", 1'b0, crc_log_o);
  endtask
  task automatic t_off_and_nonpersist();
    send(1'b0, 1'b1, 1'b0, 1'b1);
    chk1("status_off", 1'b0, crc_status_o);
    send(1'b0, 1'b0, 1'b1, 1'b1);
    alert_chk();
  endtask
  task automatic t_back_to_back();
    @(posedge mclk_i);
    wr_valid_i <= 1'b1;
    wr_i       <= {1'b0, PAT, 8'h00, ~ref_crc(1'b0, 1'b0)};
    @(posedge mclk_i);
    wr_i <= {1'b1, PAT, 8'h00, ~ref_crc(1'b1, 1'b0)};
    @(posedge mclk_i);
    wr_valid_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk1("err_a", 1'b1, crc_err_o);
    @(posedge mclk_i);
    #1;
    chk1("err_b", 1'b1, crc_err_o);
    wait_pulse();
    chk8("merged", 8'h03, crc_cnt);
    chk8("merged_width", 8'h09, width);
  endtask
  task automatic t_parity();
    @(posedge mclk_i);
    parity_err_i <= 1'b1;
    @(posedge mclk_i);
    parity_err_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk1("par_oe", 1'b1, alert_oe_o);
    wait_pulse();
    chk8("par_pulses", 8'h01, par_cnt);
    chk8("par_width", 8'h30, width);
  endtask
  initial begin
    rst_n_i      = 1'b0;
    wr_valid_i   = 1'b0;
    wr_i         = '0;
    crc_wr_en_i  = 1'b0;
    mask_fn_en_i = 1'b0;
    mrs_valid_i  = 1'b0;
    mrs_i        = '0;
    parity_err_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_good_maps();
    t_bad_discard();
    t_clear();
    t_off_and_nonpersist();
    t_back_to_back();
    t_parity();
    print_verdict();
  end
endmodule
